//--- design/fbdl_pkg.sv
// Shared constants, types and lookup functions of the feedback divider and lock detector
package fbdl_pkg;

   // -----------------------------------------------------------
   // Widths
   // -----------------------------------------------------------
   localparam int MAIN_W = 13;
   localparam int SWALLOW_W = 6;
   localparam int REF_W = 14;
   localparam int PCNT_W = 6;
   localparam int DIFF_W = 8;
   localparam int LCNT_W = 8;
   localparam int TAPS = 8;

   // -----------------------------------------------------------
   // Delay cell timing
   // -----------------------------------------------------------
   localparam int DELAY_SPAN_PS = 1000;
   localparam int CLK_PERIOD_PS = 5000;
   // Least step rounds up; a sub-cycle step still takes one cycle
   localparam int DELAY_STEP_CYCLES =
      ((DELAY_SPAN_PS / TAPS) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SR_LEN = TAPS * DELAY_STEP_CYCLES;
   localparam logic [2:0] DELAY_CODE_MAX = 3'h7;

   // -----------------------------------------------------------
   // Prescaler modes and moduli
   // -----------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_FIXED_1 = 3'b000,
      MODE_FIXED_2 = 3'b001,
      MODE_FIXED_3 = 3'b010,
      MODE_DUAL_2 = 3'b011,
      MODE_DUAL_4 = 3'b100,
      MODE_DUAL_8 = 3'b101,
      MODE_DUAL_16 = 3'b110,
      MODE_DUAL_32 = 3'b111
   } fbdl_mode_t;

   localparam logic [PCNT_W-1:0] MOD_1 = 6'h01;
   localparam logic [PCNT_W-1:0] MOD_2 = 6'h02;
   localparam logic [PCNT_W-1:0] MOD_3 = 6'h03;
   localparam logic [PCNT_W-1:0] MOD_4 = 6'h04;
   localparam logic [PCNT_W-1:0] MOD_8 = 6'h08;
   localparam logic [PCNT_W-1:0] MOD_16 = 6'h10;
   localparam logic [PCNT_W-1:0] MOD_32 = 6'h20;
   localparam logic [PCNT_W-1:0] MOD_STEP = 6'h01;

   localparam logic [MAIN_W-1:0] MAIN_BYPASS = 13'h0001;
   localparam logic [REF_W-1:0] REF_DIV1_MAX = 14'h0001;
   localparam logic [1:0] RESYNC_CTRL_OFF = 2'h0;

   // -----------------------------------------------------------
   // Lock detector
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_REF_LEAD = 2'b01,
      PH_FB_LEAD = 2'b10
   } fbdl_phase_t;

   localparam logic [DIFF_W-1:0] DIFF_START = 8'h01;
   localparam logic [DIFF_W-1:0] DIFF_MAX = 8'hFF;
   localparam logic [DIFF_W-1:0] LOCK_BASE_NARROW = 8'h02;
   localparam logic [DIFF_W-1:0] LOCK_BASE_WIDE = 8'h06;
   localparam logic [DIFF_W-1:0] UNLOCK_MARGIN = 8'h04;
   localparam logic [LCNT_W-1:0] LOCK_CYC_0 = 8'h05;
   localparam logic [LCNT_W-1:0] LOCK_CYC_1 = 8'h10;
   localparam logic [LCNT_W-1:0] LOCK_CYC_2 = 8'h40;
   localparam logic [LCNT_W-1:0] LOCK_CYC_3 = 8'hFF;

   typedef enum logic [1:0] {
      LOCK_PIN_LOW = 2'b00,
      LOCK_PIN_DIGITAL = 2'b01,
      LOCK_PIN_ANALOG_PD = 2'b10,
      LOCK_PIN_ANALOG_PU = 2'b11
   } fbdl_lock_pin_t;

   typedef enum logic [1:0] {
      PIN_LOW = 2'b00,
      PIN_LOCK = 2'b01,
      PIN_LOCK_N = 2'b10,
      PIN_HIGH = 2'b11
   } fbdl_pin_sel_t;

   function automatic logic [PCNT_W-1:0] presc_base(input fbdl_mode_t mode);
      unique case (mode)
         MODE_FIXED_1: return MOD_1;
         MODE_FIXED_2: return MOD_2;
         MODE_FIXED_3: return MOD_3;
         MODE_DUAL_2: return MOD_2;
         MODE_DUAL_4: return MOD_4;
         MODE_DUAL_8: return MOD_8;
         MODE_DUAL_16: return MOD_16;
         MODE_DUAL_32: return MOD_32;
      endcase
   endfunction

   function automatic logic is_fixed(input fbdl_mode_t mode);
      return mode inside {MODE_FIXED_1, MODE_FIXED_2, MODE_FIXED_3};
   endfunction

   function automatic logic [DIFF_W-1:0] lock_thr(input logic win, input logic [1:0] abp);
      return (win ? LOCK_BASE_WIDE : LOCK_BASE_NARROW) + DIFF_W'(abp);
   endfunction

   function automatic logic [LCNT_W-1:0] lock_cycles(input logic [1:0] sel);
      unique case (sel)
         2'h0: return LOCK_CYC_0;
         2'h1: return LOCK_CYC_1;
         2'h2: return LOCK_CYC_2;
         2'h3: return LOCK_CYC_3;
      endcase
   endfunction

endpackage

//--- design/fbdl_prescaler.sv
// Fixed or dual-modulus prescaler counting oscillator ticks
`timescale 1ns/1ps
module fbdl_prescaler (
   input logic clk,
   input logic rst_n,
   input logic clear,
   input logic tick,
   input fbdl_pkg::fbdl_mode_t mode,
   input logic swallow,
   output logic pulse
);
   import fbdl_pkg::*;

   typedef struct packed {
      logic [PCNT_W-1:0] cnt;
      logic pulse;
   } fbdl_presc_state_t;

   fbdl_presc_state_t st_reg;
   fbdl_presc_state_t st_next;
   logic [PCNT_W-1:0] modulus;

   // -----------------------------------------------------------
   // Counter
   // -----------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.pulse = 1'b0;
      // Modulus is compared on every tick; swallow has settled by the time the count reaches P-1, so a late swallow update is harmless
      modulus = presc_base(mode) + (swallow ? MOD_STEP : '0);
      if (clear) begin
         st_next.cnt = '0;
      end else if (tick) begin
         if (st_reg.cnt >= modulus - MOD_STEP) begin
            st_next.cnt = '0;
            st_next.pulse = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + MOD_STEP;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pulse = st_reg.pulse;

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   AST_PRESC_FIXED1: assert property (@(posedge clk) disable iff (!rst_n)
      (mode == MODE_FIXED_1 && tick && !clear) |=> pulse)
      else $error("divide-by-one prescaler missed a tick");

   AST_PRESC_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
      pulse |-> ($past(tick) && !$past(clear)))
      else $error("prescaler pulse without a tick");

endmodule // fbdl_prescaler

//--- design/fbdl_delay_cell.sv
// Optional programmable delay for a divider output pulse
`timescale 1ns/1ps
module fbdl_delay_cell (
   input logic clk,
   input logic rst_n,
   input logic en,
   input logic [2:0] code,
   input logic in_pulse,
   output logic out_pulse
);
   import fbdl_pkg::*;

   typedef struct packed {
      logic [SR_LEN-1:0] sr;
      logic out;
   } fbdl_delay_state_t;

   fbdl_delay_state_t st_reg;
   fbdl_delay_state_t st_next;

   // -----------------------------------------------------------
   // Tap line
   // -----------------------------------------------------------
   // Steps are whole core cycles, coarser than the analog cell
   always_comb begin
      st_next = st_reg;
      st_next.sr = {st_reg.sr[SR_LEN-2:0], in_pulse};
      st_next.out = en ? st_reg.sr[int'(code) * DELAY_STEP_CYCLES] : in_pulse;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign out_pulse = st_reg.out;

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   AST_DELAY_MAX: assert property (@(posedge clk) disable iff (!rst_n)
      (en && code == DELAY_CODE_MAX && in_pulse) ##8 (en && code == DELAY_CODE_MAX)
      |=> out_pulse)
      else $error("longest delay tap did not deliver the pulse");

   AST_DELAY_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (!en && in_pulse) |=> out_pulse)
      else $error("bypassed delay cell lost a pulse");

endmodule // fbdl_delay_cell

//--- design/fbdl_top.sv
// Feedback divider, reference divider, delay cells and lock detector of the synthesizer loop
//
// Overview of operation
// - Prescaler divides fixed 1/2/3, or dual modulus P/P+1 for P=2/4/8/16/32.
// - Dual modulus total ratio equals P times main count plus swallow count, while swallow count does not exceed main count.
// - Fixed-divide mode ignores swallow count; ratio is P times main count.
// - Mode combinations reach every integer ratio from 1 to 262175.
// - Main count of one bypasses counters; ratio equals the prescaler setting.
// - Own reset or shared reset bit holds swallow and main counters; not self-clearing.
// - Resync pin, when enabled, resets reference, swallow and main counters together.
// - Each divider output passes an optional three-bit programmable delay cell.
// - Lock declared after programmed run of cycles below the lock threshold.
// - Lock drops on one cycle above the wider unlock threshold.
// - Window bit and antibacklash setting choose the lock and unlock widths.
// - Digital lock routed through per-pin muxes to lock, status, monitor pins.
// - Analog lock pin offers open-drain pull-down and pull-up pulse variants.
// - Fourteen-bit reference divider; programmed zero and one both divide by one.
`timescale 1ns/1ps
module fbdl_top (
   input logic CORE_CLK,
   input logic RST_N,
   input logic VCO_TICK,
   input logic REF_TICK,
   input logic RESYNC_N,
   input fbdl_pkg::fbdl_mode_t PRESCALE_MODE,
   input logic [fbdl_pkg::MAIN_W-1:0] MAIN_COUNT,
   input logic [fbdl_pkg::SWALLOW_W-1:0] SWALLOW_COUNT,
   input logic [fbdl_pkg::REF_W-1:0] REF_COUNT,
   input logic FB_CNT_RESET,
   input logic REF_CNT_RESET,
   input logic SHARED_CNT_RESET,
   input logic [1:0] RESYNC_RESET_CTRL,
   input logic REF_DELAY_EN,
   input logic [2:0] REF_DELAY_CODE,
   input logic FB_DELAY_EN,
   input logic [2:0] FB_DELAY_CODE,
   input logic LOCK_WINDOW_SEL,
   input logic [1:0] ANTIBACKLASH_SEL,
   input logic [1:0] LOCK_COUNT_SEL,
   input fbdl_pkg::fbdl_lock_pin_t LOCK_PIN_SEL,
   input fbdl_pkg::fbdl_pin_sel_t STATUS_PIN_SEL,
   input fbdl_pkg::fbdl_pin_sel_t MONITOR_PIN_SEL,
   output logic REF_PHASE_PULSE,
   output logic FB_PHASE_PULSE,
   output logic DIGITAL_LOCK_INDICATOR,
   output logic LOCK_INDICATOR_PIN_O,
   output logic LOCK_INDICATOR_PIN_OE,
   output logic STATUS_PIN_O,
   output logic REFERENCE_MONITOR_PIN_O
);
   import fbdl_pkg::*;

   typedef struct packed {
      logic [REF_W-1:0] r_cnt;
      logic ref_raw;
      logic [MAIN_W-1:0] b_cnt;
      logic fb_raw;
      fbdl_phase_t phase;
      logic [DIFF_W-1:0] diff_cnt;
      logic [LCNT_W-1:0] lock_cnt;
      logic locked;
      logic lock_o;
      logic lock_oe;
      logic status_o;
      logic monitor_o;
   } fbdl_top_state_t;

   fbdl_top_state_t st_reg;
   fbdl_top_state_t st_next;

   logic sync_rst;
   logic n_clear;
   logic r_clear;
   logic fixed;
   logic bypass;
   logic swallow;
   logic presc_pulse;
   logic ref_p;
   logic fb_p;
   logic lead_p;
   logic lag_p;
   logic meas_v;
   logic [DIFF_W-1:0] meas_d;
   logic [DIFF_W-1:0] thr_lock;
   logic [DIFF_W-1:0] thr_unlock;
   logic [LCNT_W-1:0] lock_last;

   function automatic logic pin_mux(input fbdl_pin_sel_t sel, input logic lk);
      unique case (sel)
         PIN_LOW: return 1'b0;
         PIN_LOCK: return lk;
         PIN_LOCK_N: return !lk;
         PIN_HIGH: return 1'b1;
      endcase
   endfunction

   // -----------------------------------------------------------
   // Counter resets and mode decode
   // -----------------------------------------------------------
   // Resync pin is a level reset; it holds the counters while low
   assign sync_rst = (RESYNC_RESET_CTRL != RESYNC_CTRL_OFF) && !RESYNC_N;
   assign n_clear = FB_CNT_RESET || SHARED_CNT_RESET || sync_rst;
   assign r_clear = REF_CNT_RESET || SHARED_CNT_RESET || sync_rst;
   assign fixed = is_fixed(PRESCALE_MODE);
   assign bypass = (MAIN_COUNT <= MAIN_BYPASS);
   // First swallow-count pulses of each main cycle use P+1
   assign swallow = !fixed && !bypass && (MAIN_W'(SWALLOW_COUNT) > st_reg.b_cnt);

   assign thr_lock = lock_thr(LOCK_WINDOW_SEL, ANTIBACKLASH_SEL);
   assign thr_unlock = thr_lock + UNLOCK_MARGIN;
   assign lock_last = lock_cycles(LOCK_COUNT_SEL) - 1'b1;

   fbdl_prescaler u_presc (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .clear(n_clear),
      .tick(VCO_TICK),
      .mode(PRESCALE_MODE),
      .swallow(swallow),
      .pulse(presc_pulse)
   );

   fbdl_delay_cell u_ref_delay (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .en(REF_DELAY_EN),
      .code(REF_DELAY_CODE),
      .in_pulse(st_reg.ref_raw),
      .out_pulse(ref_p)
   );

   fbdl_delay_cell u_fb_delay (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .en(FB_DELAY_EN),
      .code(FB_DELAY_CODE),
      .in_pulse(st_reg.fb_raw),
      .out_pulse(fb_p)
   );

   // -----------------------------------------------------------
   // Dividers, phase timing and lock
   // -----------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      meas_v = 1'b0;
      meas_d = '0;
      lead_p = 1'b0;
      lag_p = 1'b0;
      st_next.ref_raw = 1'b0;
      st_next.fb_raw = 1'b0;

      if (r_clear) begin
         st_next.r_cnt = '0;
      end else if (REF_TICK) begin
         if (REF_COUNT <= REF_DIV1_MAX || st_reg.r_cnt >= REF_COUNT - 1'b1) begin
            st_next.r_cnt = '0;
            st_next.ref_raw = 1'b1;
         end else begin
            st_next.r_cnt = st_reg.r_cnt + 1'b1;
         end
      end

      // Main counter counts prescaler pulses; ratio is P*B + A in dual modes with A <= B, P*B in fixed modes
      if (n_clear) begin
         st_next.b_cnt = '0;
      end else if (presc_pulse) begin
         if (bypass || st_reg.b_cnt >= MAIN_COUNT - 1'b1) begin
            st_next.b_cnt = '0;
            st_next.fb_raw = 1'b1;
         end else begin
            st_next.b_cnt = st_reg.b_cnt + 1'b1;
         end
      end

      unique case (st_reg.phase)
         PH_IDLE: begin
            if (ref_p && fb_p) begin
               meas_v = 1'b1;
            end else if (ref_p) begin
               st_next.phase = PH_REF_LEAD;
               st_next.diff_cnt = DIFF_START;
            end else if (fb_p) begin
               st_next.phase = PH_FB_LEAD;
               st_next.diff_cnt = DIFF_START;
            end
         end
         PH_REF_LEAD, PH_FB_LEAD: begin
            lead_p = (st_reg.phase == PH_REF_LEAD) ? ref_p : fb_p;
            lag_p = (st_reg.phase == PH_REF_LEAD) ? fb_p : ref_p;
            if (lag_p) begin
               meas_v = 1'b1;
               meas_d = st_reg.diff_cnt;
               st_next.phase = PH_IDLE;
            end else if (lead_p) begin
               // Second leading edge with no partner counts as a gross error
               meas_v = 1'b1;
               meas_d = DIFF_MAX;
               st_next.diff_cnt = DIFF_START;
            end else if (st_reg.diff_cnt != DIFF_MAX) begin
               st_next.diff_cnt = st_reg.diff_cnt + 1'b1;
            end
         end
         default: begin
            st_next.phase = PH_IDLE;
         end
      endcase

      if (meas_v) begin
         if (st_reg.locked) begin
            if (meas_d > thr_unlock) begin
               st_next.locked = 1'b0;
               st_next.lock_cnt = '0;
            end
         end else if (meas_d < thr_lock) begin
            if (st_reg.lock_cnt >= lock_last) begin
               st_next.locked = 1'b1;
               st_next.lock_cnt = '0;
            end else begin
               st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
            end
         end else begin
            st_next.lock_cnt = '0;
         end
      end

      // Analog indication pulses for the whole phase error interval
      unique case (LOCK_PIN_SEL)
         LOCK_PIN_LOW: begin
            st_next.lock_o = 1'b0;
            st_next.lock_oe = 1'b1;
         end
         LOCK_PIN_DIGITAL: begin
            st_next.lock_o = st_next.locked;
            st_next.lock_oe = 1'b1;
         end
         LOCK_PIN_ANALOG_PD: begin
            st_next.lock_o = 1'b0;
            st_next.lock_oe = (st_next.phase != PH_IDLE);
         end
         LOCK_PIN_ANALOG_PU: begin
            st_next.lock_o = 1'b1;
            st_next.lock_oe = (st_next.phase != PH_IDLE);
         end
      endcase
      st_next.status_o = pin_mux(STATUS_PIN_SEL, st_next.locked);
      st_next.monitor_o = pin_mux(MONITOR_PIN_SEL, st_next.locked);
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign REF_PHASE_PULSE = ref_p;
   assign FB_PHASE_PULSE = fb_p;
   assign DIGITAL_LOCK_INDICATOR = st_reg.locked;
   assign LOCK_INDICATOR_PIN_O = st_reg.lock_o;
   assign LOCK_INDICATOR_PIN_OE = st_reg.lock_oe;
   assign STATUS_PIN_O = st_reg.status_o;
   assign REFERENCE_MONITOR_PIN_O = st_reg.monitor_o;

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   AST_FIXED_NO_SWALLOW: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      fixed |-> !swallow)
      else $error("swallow active in fixed-divide mode");

   AST_BYPASS_NO_SWALLOW: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (bypass && presc_pulse && !n_clear) |-> (!swallow ##1 st_reg.fb_raw))
      else $error("bypassed main counter did not pass the prescaler pulse");

   AST_MAIN_HELD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      n_clear [*2] |=> (!st_reg.fb_raw && st_reg.b_cnt == '0))
      else $error("main counter ran while held in reset");

   AST_RESYNC_CLEARS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (!RESYNC_N && RESYNC_RESET_CTRL != RESYNC_CTRL_OFF)
      |=> (st_reg.r_cnt == '0 && st_reg.b_cnt == '0))
      else $error("resync pin did not clear both dividers");

   AST_REF_DIV1: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (REF_COUNT <= REF_DIV1_MAX && REF_TICK && !r_clear) |=> st_reg.ref_raw)
      else $error("reference count of zero or one did not divide by one");

   AST_LOCK_RUN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(st_reg.locked) |-> ($past(st_reg.lock_cnt) >= $past(lock_last)
      && $past(meas_v) && $past(meas_d) < $past(thr_lock)))
      else $error("lock declared without the programmed run of good cycles");

   AST_UNLOCK: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.locked && meas_v && meas_d > thr_unlock) |=> !st_reg.locked)
      else $error("lock kept after a cycle beyond the unlock window");

   AST_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.locked && !(meas_v && meas_d > thr_unlock)) |=> st_reg.locked)
      else $error("lock dropped without a cycle beyond the unlock window");

   AST_HYSTERESIS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      thr_unlock > thr_lock)
      else $error("unlock window not wider than lock window");

   AST_LOCK_PIN_DIGITAL: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (LOCK_PIN_SEL == LOCK_PIN_DIGITAL)
      |=> (LOCK_INDICATOR_PIN_OE && LOCK_INDICATOR_PIN_O == DIGITAL_LOCK_INDICATOR))
      else $error("lock pin does not follow the digital lock");

   AST_LOCK_PIN_ANALOG: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (LOCK_PIN_SEL == LOCK_PIN_ANALOG_PD)
      |=> (!LOCK_INDICATOR_PIN_O && LOCK_INDICATOR_PIN_OE == (st_reg.phase != PH_IDLE)))
      else $error("pull-down analog lock pin not pulsing with phase error");

   COV_LOCK: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(st_reg.locked));
   COV_UNLOCK: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      $fell(st_reg.locked));
   COV_SWALLOW_CYCLE: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      swallow ##[1:200] st_reg.fb_raw);
   COV_FB_LEAD: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg.phase == PH_FB_LEAD ##1 st_reg.phase == PH_IDLE);

endmodule // fbdl_top

//--- testbench/tb_fbdl_top.sv
// Self-checking bench for the feedback divider and lock detector
`timescale 1ns/1ps
module tb_fbdl_top;
   import fbdl_pkg::*;
   logic CORE_CLK, RST_N, VCO_TICK, REF_TICK, RESYNC_N, FB_CNT_RESET, REF_CNT_RESET;
   logic SHARED_CNT_RESET, REF_DELAY_EN, FB_DELAY_EN, LOCK_WINDOW_SEL;
   fbdl_mode_t PRESCALE_MODE;
   logic [MAIN_W-1:0] MAIN_COUNT;
   logic [SWALLOW_W-1:0] SWALLOW_COUNT;
   logic [REF_W-1:0] REF_COUNT;
   logic [1:0] RESYNC_RESET_CTRL, ANTIBACKLASH_SEL, LOCK_COUNT_SEL;
   logic [2:0] REF_DELAY_CODE, FB_DELAY_CODE;
   fbdl_lock_pin_t LOCK_PIN_SEL;
   fbdl_pin_sel_t STATUS_PIN_SEL, MONITOR_PIN_SEL;
   logic REF_PHASE_PULSE, FB_PHASE_PULSE, DIGITAL_LOCK_INDICATOR, LOCK_INDICATOR_PIN_O;
   logic LOCK_INDICATOR_PIN_OE, STATUS_PIN_O, REFERENCE_MONITOR_PIN_O;
   int err_total = 0;
   int tests_run = 0;
   int cf, cr, p;

   fbdl_top i_fbdl_top (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .VCO_TICK(VCO_TICK),
      .REF_TICK(REF_TICK), .RESYNC_N(RESYNC_N), .PRESCALE_MODE(PRESCALE_MODE),
      .MAIN_COUNT(MAIN_COUNT), .SWALLOW_COUNT(SWALLOW_COUNT), .REF_COUNT(REF_COUNT),
      .FB_CNT_RESET(FB_CNT_RESET), .REF_CNT_RESET(REF_CNT_RESET),
      .SHARED_CNT_RESET(SHARED_CNT_RESET), .RESYNC_RESET_CTRL(RESYNC_RESET_CTRL),
      .REF_DELAY_EN(REF_DELAY_EN), .REF_DELAY_CODE(REF_DELAY_CODE),
      .FB_DELAY_EN(FB_DELAY_EN), .FB_DELAY_CODE(FB_DELAY_CODE),
      .LOCK_WINDOW_SEL(LOCK_WINDOW_SEL), .ANTIBACKLASH_SEL(ANTIBACKLASH_SEL),
      .LOCK_COUNT_SEL(LOCK_COUNT_SEL), .LOCK_PIN_SEL(LOCK_PIN_SEL),
      .STATUS_PIN_SEL(STATUS_PIN_SEL), .MONITOR_PIN_SEL(MONITOR_PIN_SEL),
      .REF_PHASE_PULSE(REF_PHASE_PULSE), .FB_PHASE_PULSE(FB_PHASE_PULSE),
      .DIGITAL_LOCK_INDICATOR(DIGITAL_LOCK_INDICATOR),
      .LOCK_INDICATOR_PIN_O(LOCK_INDICATOR_PIN_O), .LOCK_INDICATOR_PIN_OE(LOCK_INDICATOR_PIN_OE),
      .STATUS_PIN_O(STATUS_PIN_O), .REFERENCE_MONITOR_PIN_O(REFERENCE_MONITOR_PIN_O));

   initial begin
      CORE_CLK = 1'b0;
      forever #2.5 CORE_CLK = ~CORE_CLK;
   end

   // ---------------------------------------------
   // Access tasks
   // ---------------------------------------------
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %0d seen %0d", nm, e, g);
         err_total++;
      end
   endtask

   // Inputs move 1 ns after the edge, outputs read there too
   task automatic step(input int n);
      repeat (n) begin
         @(posedge CORE_CLK);
         #1;
      end
   endtask

   function automatic logic pl(input logic fb);
      return fb ? FB_PHASE_PULSE : REF_PHASE_PULSE;
   endfunction

   // Cycles between two pulses; a missing pulse ends the run
   task automatic period(input logic fb, output int n);
      int k;
      k = 0;
      while (pl(fb) !== 1'b1 && k < 3000) begin
         step(1);
         k++;
      end
      n = 0;
      do begin
         step(1);
         n++;
      end while (pl(fb) !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         chk("pulse_timeout", 0, 1);
         complete_run();
      end
   endtask

   task automatic div_case(input fbdl_mode_t m, input int b, input int a, input int n);
      PRESCALE_MODE = m;
      MAIN_COUNT = MAIN_W'(b);
      SWALLOW_COUNT = SWALLOW_W'(a);
      step(2);
      period(1'b1, p);
      period(1'b1, p);
      chk("fb_ratio", n, p);
   endtask

   task automatic ref_case(input int r, input int n);
      REF_COUNT = REF_W'(r);
      step(2);
      period(1'b0, p);
      period(1'b0, p);
      chk("ref_ratio", n, p);
   endtask

   task automatic count(input int n);
      // Let pulses already in the pipeline drain first
      step(3);
      cf = 0;
      cr = 0;
      repeat (n) begin
         step(1);
         cf += FB_PHASE_PULSE;
         cr += REF_PHASE_PULSE;
      end
   endtask

   task automatic wait_lock(input logic v);
      int k;
      k = 0;
      while (DIGITAL_LOCK_INDICATOR !== v && k < 400) begin
         step(1);
         k++;
      end
      chk("lock", v, DIGITAL_LOCK_INDICATOR);
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      RST_N = 1'b0; VCO_TICK = 1'b1; REF_TICK = 1'b1; RESYNC_N = 1'b1;
      FB_CNT_RESET = 1'b0; REF_CNT_RESET = 1'b0; SHARED_CNT_RESET = 1'b0;
      REF_DELAY_EN = 1'b0; FB_DELAY_EN = 1'b0; LOCK_WINDOW_SEL = 1'b0;
      PRESCALE_MODE = MODE_FIXED_1; MAIN_COUNT = 13'h0001; SWALLOW_COUNT = 6'h00;
      REF_COUNT = 14'h0000; RESYNC_RESET_CTRL = 2'h0; ANTIBACKLASH_SEL = 2'h0;
      LOCK_COUNT_SEL = 2'h0; REF_DELAY_CODE = 3'h0; FB_DELAY_CODE = 3'h0;
      LOCK_PIN_SEL = LOCK_PIN_DIGITAL; STATUS_PIN_SEL = PIN_LOCK; MONITOR_PIN_SEL = PIN_LOCK_N;
      step(3);
      RST_N = 1'b1;
      div_case(MODE_FIXED_1, 1, 0, 1);
      div_case(MODE_FIXED_3, 5, 0, 15);
      div_case(MODE_FIXED_2, 3, 7, 6);
      div_case(MODE_DUAL_2, 3, 2, 8);
      div_case(MODE_DUAL_4, 3, 0, 12);
      div_case(MODE_DUAL_8, 18, 7, 151);
      div_case(MODE_DUAL_16, 9, 7, 151);
      div_case(MODE_DUAL_32, 1, 0, 32);
      ref_case(0, 1);
      ref_case(1, 1);
      ref_case(5, 5);
      $display("Divider ratio tests done");
      div_case(MODE_DUAL_2, 3, 1, 7);
      FB_CNT_RESET = 1'b1;
      count(40);
      chk("fb_reset_held", 0, cf);
      FB_CNT_RESET = 1'b0;
      SHARED_CNT_RESET = 1'b1;
      count(40);
      chk("shared_reset", 0, cf + cr);
      SHARED_CNT_RESET = 1'b0;
      RESYNC_N = 1'b0;
      count(40);
      chk("resync_off", 1, cf != 0 && cr != 0);
      for (int c = 1; c < 4; c++) begin
         RESYNC_RESET_CTRL = 2'(c);
         count(40);
         chk("resync_on", 0, cf + cr);
      end
      RESYNC_N = 1'b1;
      $display("Counter reset tests done");
      // Period of 20 keeps a delayed skew from pairing with the next edge
      REF_COUNT = 14'h0014;
      div_case(MODE_DUAL_2, 10, 0, 20);
      // Detector keeps its run across counter resets; a full reset starts it fresh
      RST_N = 1'b0;
      step(3);
      RST_N = 1'b1;
      // Fewer than five good pairs cannot lock yet
      repeat (3) period(1'b0, p);
      chk("early_lock", 0, DIGITAL_LOCK_INDICATOR);
      wait_lock(1'b1);
      step(1);
      chk("status_pin", 1, STATUS_PIN_O);
      chk("monitor_pin", 0, REFERENCE_MONITOR_PIN_O);
      chk("lock_pin", 1, LOCK_INDICATOR_PIN_O);
      // Eight extra cycles of delay push the skew past the unlock window
      FB_DELAY_EN = 1'b1;
      FB_DELAY_CODE = 3'h7;
      wait_lock(1'b0);
      step(1);
      chk("status_pin_off", 0, STATUS_PIN_O);
      chk("monitor_pin_off", 1, REFERENCE_MONITOR_PIN_O);
      LOCK_PIN_SEL = LOCK_PIN_ANALOG_PD;
      step(2);
      chk("analog_pd_level", 0, LOCK_INDICATOR_PIN_O);
      cf = 0;
      repeat (40) begin
         step(1);
         cf += LOCK_INDICATOR_PIN_OE;
      end
      chk("analog_pd_pulsing", 1, cf > 0 && cf < 40);
      $display("Lock detector tests done");
      complete_run();
   end
endmodule // tb_fbdl_top
